// file: dcb_chan_proc.sv
// Per-channel DC block filter, test-signal select and phase-trimmed windows
// Assumes one 200 MHz clock, mod_tick_i one pulse per modulator cycle
//
// Behaviour
// - Codes 1h to Fh give a coefficient of one over two to the code plus one.
// - Any nonzero coefficient code is the global filter enable.
// - A channel's own disable bit bypasses the filter for that channel.
// - Each channel's input select can route a shared positive or negative test level.
// - The test level reads as two fifteenths of full scale while the filter is bypassed.
// - Each phase trim is a 10-bit two's complement count of modulator cycles.
// - Trim is limited to -OSR/2 .. OSR/2-1, and to -512 .. 511 above OSR 1024.
// - Out-of-range trim saturates to the nearest limit instead of wrapping.
// - Each result window spans OSR modulator samples.
// - With zero trim every channel's window is aligned with the others.
// - The data-ready indication waits for the latest trimmed window.
`timescale 1ns/1ps
`default_nettype none

module dcb_chan_proc
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Avalon-MM slave
    input wire logic [dcb_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Modulator timing
    input wire logic mod_tick_i,
    output logic [dcb_pkg::NUM_CH-1:0] chan_window_o,
    output logic result_ready_n_o,
    // Results from decimation
    input wire logic res_valid_i,
    input wire logic [dcb_pkg::CH_W-1:0] res_chan_i,
    input wire logic [dcb_pkg::DATA_W-1:0] res_data_i,
    output logic res_ready_o,
    // Processed results
    output logic out_valid_o,
    output logic [dcb_pkg::CH_W-1:0] out_chan_o,
    output logic [dcb_pkg::DATA_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    import dcb_pkg::*;

    // ****************************************************************
    // Register slave
    // ****************************************************************
    logic [COEF_W-1:0] hpf_coef_code, next_hpf_coef_code;
    logic [OSR_W-1:0] osr_sel, next_osr_sel;
    logic [CFG_W-1:0] chan_config_reg [NUM_CH], next_chan_config_reg [NUM_CH];
    logic [31:0] next_rdata;
    logic next_wait;
    logic [NUM_CH-1:0] done_mask, next_done_mask;
    logic [ADDR_W-1:0] chan_off;
    logic [CH_W-1:0] chan_idx;
    logic chan_hit;

    always_comb
    begin
        chan_off = avs_address_i - ADDR_CHAN_BASE;
        chan_idx = chan_off[CH_W+1:2];
        chan_hit = (avs_address_i >= ADDR_CHAN_BASE)
            && (avs_address_i <= ADDR_CHAN_LAST)
            && (avs_address_i[1:0] == 2'h0);
        next_hpf_coef_code = hpf_coef_code;
        next_osr_sel = osr_sel;
        next_chan_config_reg = chan_config_reg;
        next_rdata = avs_readdata_o;
        next_wait = 1'b1;
        if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
        begin
            next_wait = 1'b0;
            next_rdata = 32'h0000_0000;
            if (avs_address_i == ADDR_GLOBAL)
            begin
                next_rdata[COEF_LSB +: COEF_W] = hpf_coef_code;
                next_rdata[OSR_LSB +: OSR_W] = osr_sel;
            end
            else if (avs_address_i == ADDR_STATUS)
            begin
                next_rdata[NUM_CH-1:0] = done_mask;
                next_rdata[NUM_CH] = result_ready_n_o;
            end
            else if (chan_hit)
                next_rdata[CFG_W-1:0] = chan_config_reg[chan_idx];
        end
        if (avs_write_i && !avs_waitrequest_o)
        begin
            if (avs_address_i == ADDR_GLOBAL)
            begin
                next_hpf_coef_code = avs_writedata_i[COEF_LSB +: COEF_W];
                next_osr_sel = avs_writedata_i[OSR_LSB +: OSR_W];
            end
            else if (chan_hit)
                next_chan_config_reg[chan_idx] = avs_writedata_i[CFG_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hpf_coef_code <= COEF_RST;
            osr_sel <= OSR_RST;
            for (int i = 0; i < NUM_CH; i++)
                chan_config_reg[i] <= CHAN_CFG_RST;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end
        else if (ce_i)
        begin
            hpf_coef_code <= next_hpf_coef_code;
            osr_sel <= next_osr_sel;
            chan_config_reg <= next_chan_config_reg;
            avs_readdata_o <= next_rdata;
            avs_waitrequest_o <= next_wait;
        end
    end

    // ****************************************************************
    // Reference window and trimmed channel windows
    // ****************************************************************
    logic [15:0] osr;
    logic [15:0] win_cnt, next_win_cnt;
    logic signed [15:0] lim_hi;
    logic signed [15:0] clip_trim [NUM_CH];
    logic [15:0] end_pos [NUM_CH];
    logic [NUM_CH-1:0] next_window;
    logic next_ready_n;

    always_comb
    begin
        osr = OSR_BASE << osr_sel;
        lim_hi = $signed(osr >> 1) - 16'sh0001;
        if (lim_hi > TRIM_CAP)
            lim_hi = TRIM_CAP;
    end

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_win
        logic signed [15:0] raw_trim;
        logic signed [15:0] pos;
        assign raw_trim = 16'($signed(chan_config_reg[c][TRIM_LSB +: TRIM_W]));
        assign clip_trim[c] = (raw_trim > lim_hi) ? lim_hi
            : (raw_trim < -lim_hi - 16'sh0001) ? -lim_hi - 16'sh0001 : raw_trim;
        assign pos = $signed(osr) - 16'sh0001 + clip_trim[c];
        assign end_pos[c] = ($unsigned(pos) >= osr) ? $unsigned(pos) - osr
            : $unsigned(pos);
        assign next_window[c] = mod_tick_i && (win_cnt == end_pos[c]);
    end

    always_comb
    begin
        next_win_cnt = win_cnt;
        if (mod_tick_i)
            next_win_cnt = (win_cnt >= osr - 16'h0001) ? 16'h0000
                : win_cnt + 16'h0001;
        next_done_mask = done_mask | chan_window_o;
        next_ready_n = 1'b1;
        if (&next_done_mask)
        begin
            next_ready_n = 1'b0;
            next_done_mask = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            win_cnt <= 16'h0000;
            chan_window_o <= '0;
            done_mask <= '0;
            result_ready_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            win_cnt <= next_win_cnt;
            chan_window_o <= next_window;
            done_mask <= next_done_mask;
            result_ready_n_o <= next_ready_n;
        end
    end

    // ****************************************************************
    // Input select and DC block filter
    // ****************************************************************
    logic signed [DATA_W-1:0] xprev [NUM_CH], next_xprev [NUM_CH];
    logic signed [ACC_W-1:0] yacc [NUM_CH], next_yacc [NUM_CH];
    logic signed [DATA_W-1:0] x_sel;
    logic signed [ACC_W-1:0] y_new, y_int;
    logic [DATA_W-1:0] res_out;
    logic [COEF_W:0] hpf_shift;
    logic ch_ok, hpf_on, push;
    logic [CH_W-1:0] ch;

    always_comb
    begin
        ch_ok = (res_chan_i < CH_W'(NUM_CH));
        ch = ch_ok ? res_chan_i : '0;
        push = res_valid_i && res_ready_o;
        unique case (dcb_insel_e'(chan_config_reg[ch][SEL_LSB +: SEL_W]))
            DCB_SEL_NORMAL: x_sel = $signed(res_data_i);
            DCB_SEL_SHORT: x_sel = '0;
            DCB_SEL_TEST_POS: x_sel = TEST_LEVEL;
            DCB_SEL_TEST_NEG: x_sel = -TEST_LEVEL;
        endcase
        hpf_on = ch_ok && (hpf_coef_code != 4'h0)
            && !chan_config_reg[ch][DIS_BIT];
        hpf_shift = {1'b0, hpf_coef_code} + 5'h01;
        y_new = (ACC_W'(x_sel) <<< FRAC_W) - (ACC_W'(xprev[ch]) <<< FRAC_W)
            + yacc[ch] - (yacc[ch] >>> hpf_shift);
        y_int = y_new >>> FRAC_W;
        if (!hpf_on)
            res_out = x_sel;
        else if (y_int > SAT_HI)
            res_out = SAT_HI[DATA_W-1:0];
        else if (y_int < SAT_LO)
            res_out = SAT_LO[DATA_W-1:0];
        else
            res_out = y_int[DATA_W-1:0];
        next_xprev = xprev;
        next_yacc = yacc;
        if (push && ch_ok)
        begin
            next_xprev[ch] = x_sel;
            next_yacc[ch] = hpf_on ? y_new : '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xprev <= '{default: '0};
            yacc <= '{default: '0};
        end
        else if (ce_i)
        begin
            xprev <= next_xprev;
            yacc <= next_yacc;
        end
    end

    dcb_skid_buf dcb_skid_buf_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .in_valid_i(res_valid_i), .in_data_i({res_chan_i, res_out}),
        .in_ready_o(res_ready_o), .out_valid_o(out_valid_o),
        .out_data_o({out_chan_o, out_data_o}), .out_ready_i(out_ready_i)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        (push && hpf_coef_code == 4'h0 && x_sel == $signed(res_data_i))
            |-> (res_out == res_data_i);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("code zero did not bypass");
    property p_shift;
        @(posedge clk_i) disable iff (rst_i)
        (hpf_coef_code == 4'hF) |-> (hpf_shift == 5'h10);
    endproperty
    a_shift: assert property (p_shift)
        else $error("coefficient shift wrong");
    property p_state_clear;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && push && ch_ok && !hpf_on) |=> (yacc[$past(ch)] == '0);
    endproperty
    a_state_clear: assert property (p_state_clear)
        else $error("filter state kept while bypassed");
    property p_chan_disable;
        @(posedge clk_i) disable iff (rst_i)
        (push && chan_config_reg[ch][DIS_BIT]) |-> (res_out == x_sel);
    endproperty
    a_chan_disable: assert property (p_chan_disable)
        else $error("disabled channel was filtered");
    property p_test_pos;
        @(posedge clk_i) disable iff (rst_i)
        (push && !hpf_on && chan_config_reg[ch][SEL_LSB +: SEL_W] == 2'h2)
            |-> (res_out == TEST_LEVEL);
    endproperty
    a_test_pos: assert property (p_test_pos)
        else $error("positive test level wrong");
    property p_clip;
        @(posedge clk_i) disable iff (rst_i)
        (clip_trim[0] <= lim_hi) && (clip_trim[0] >= -lim_hi - 16'sh0001)
            && (lim_hi <= TRIM_CAP);
    endproperty
    a_clip: assert property (p_clip)
        else $error("trim outside limits");
    property p_align;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && chan_config_reg[0][TRIM_W-1:0] == '0
            && chan_config_reg[1][TRIM_W-1:0] == '0)
            |=> (chan_window_o[0] == chan_window_o[1]);
    endproperty
    a_align: assert property (p_align)
        else $error("zero-trim windows not aligned");
    property p_window_time;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && mod_tick_i && win_cnt == end_pos[0]) |=> chan_window_o[0];
    endproperty
    a_window_time: assert property (p_window_time)
        else $error("channel window pulse missing");
    property p_ready;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && &(done_mask | chan_window_o)) |=> !result_ready_n_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("data ready not raised after last window");
    property p_wait;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o)
            |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus request not answered");

endmodule

`default_nettype wire

// file: dcb_pkg.sv
// Constants, field layout and types shared by the DC block and phase trim
// Assumes a single 200 MHz clock domain and 32-bit Avalon-MM registers
`default_nettype none

package dcb_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_CH = 6;
    localparam int CH_W = 3;
    localparam int DATA_W = 24;
    localparam int FRAC_W = 16;
    localparam int ACC_W = 44;
    localparam int ADDR_W = 8;
    localparam int BUF_W = CH_W + DATA_W;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_LAST = 8'h24;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int COEF_LSB = 0;
    localparam int COEF_W = 4;
    localparam int OSR_LSB = 4;
    localparam int OSR_W = 3;
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 10;
    localparam int DIS_BIT = 10;
    localparam int SEL_LSB = 12;
    localparam int SEL_W = 2;
    localparam int CFG_W = 14;
    localparam logic [COEF_W-1:0] COEF_RST = 4'h0;
    localparam logic [OSR_W-1:0] OSR_RST = 3'h3;
    localparam logic [CFG_W-1:0] CHAN_CFG_RST = 14'h0000;

    // ****************************************************************
    // Arithmetic constants
    // ****************************************************************
    localparam logic [15:0] OSR_BASE = 16'h0080;
    localparam logic signed [15:0] TRIM_CAP = 16'sh01FF;
    localparam logic signed [DATA_W-1:0] TEST_LEVEL = 24'sh111111;
    localparam logic signed [ACC_W-1:0] SAT_HI = 44'sh000007FFFFF;
    localparam logic signed [ACC_W-1:0] SAT_LO = 44'shFFFFF800000;

    typedef enum logic [SEL_W-1:0] {
        DCB_SEL_NORMAL,
        DCB_SEL_SHORT,
        DCB_SEL_TEST_POS,
        DCB_SEL_TEST_NEG
    } dcb_insel_e;

endpackage

`default_nettype wire

// file: dcb_skid_buf.sv
// Two-entry result buffer; head entry drives the data output directly
// Assumes a synchronous source and sink on the same clock
`timescale 1ns/1ps
`default_nettype none

module dcb_skid_buf
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [dcb_pkg::BUF_W-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [dcb_pkg::BUF_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    import dcb_pkg::*;

    logic [BUF_W-1:0] mem [2];
    logic [BUF_W-1:0] next_mem [2];
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic push;
    logic pop;

    always_comb
    begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_mem = mem;
        next_cnt = cnt;
        if (pop)
        begin
            next_mem[0] = mem[1];
            next_cnt = cnt - 2'h1;
        end
        if (push)
        begin
            next_mem[next_cnt[0]] = in_data_i;
            next_cnt = next_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mem[0] <= '0;
            mem[1] <= '0;
            cnt <= 2'h0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            mem <= next_mem;
            cnt <= next_cnt;
            in_ready_o <= (next_cnt != 2'h2);
            out_valid_o <= (next_cnt != 2'h0);
        end
    end

    assign out_data_o = mem[0];

    property p_no_overflow;
        @(posedge clk_i) disable iff (rst_i)
        (cnt == 2'h2) |-> !in_ready_o;
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("buffer full but ready high");

endmodule

`default_nettype wire

// file: dcb_host_model.sv
// Host-side reader of processed results, with a stall control
// Assumes one clock shared with the block under test
`timescale 1ns/1ps
`default_nettype none

module dcb_host_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic stall_i,
    // Result stream
    input wire logic out_valid_i,
    input wire logic [dcb_pkg::CH_W-1:0] out_chan_i,
    input wire logic [dcb_pkg::DATA_W-1:0] out_data_i,
    output logic out_ready_o
);
    logic [dcb_pkg::BUF_W-1:0] rx_q[$];

    // Words are taken only at an edge where valid and ready meet
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            out_ready_o <= 1'b0;
        else
        begin
            if (out_valid_i && out_ready_o)
                rx_q.push_back({out_chan_i, out_data_i});
            out_ready_o <= !stall_i;
        end
    end
endmodule

`default_nettype wire

// file: channel_dc_block_and_phase_trim_tb.sv
// Testbench: register, data path, test level and phase trim checks
// Assumes the host model file and the design files compiled first
`timescale 1ns/1ps
`default_nettype none

module channel_dc_block_and_phase_trim_tb;
    import dcb_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, stall = 0;
    logic [7:0] avs_address_i = 0;
    logic avs_read_i = 0, avs_write_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, rd;
    logic avs_waitrequest_o, mod_tick_i = 0, result_ready_n_o;
    logic [NUM_CH-1:0] chan_window_o;
    logic res_valid_i = 0, res_ready_o, out_valid_o, out_ready_i;
    logic [CH_W-1:0] res_chan_i = 0, out_chan_o;
    logic [DATA_W-1:0] res_data_i = 0, out_data_o;
    logic [DATA_W-1:0] lvl[3] = '{24'h000000, 24'h111111, 24'hEEEEEF};
    int mismatches = 0, compares = 0, cyc = 0, rcyc = 0;
    int pcyc[NUM_CH];
    int tr[NUM_CH] = '{0, 100, -100, 5, -1, 300};

    dcb_chan_proc dcb_chan_proc_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .mod_tick_i(mod_tick_i),
        .chan_window_o(chan_window_o), .result_ready_n_o(result_ready_n_o),
        .res_valid_i(res_valid_i), .res_chan_i(res_chan_i),
        .res_data_i(res_data_i), .res_ready_o(res_ready_o),
        .out_valid_o(out_valid_o), .out_chan_o(out_chan_o),
        .out_data_o(out_data_o), .out_ready_i(out_ready_i));

    dcb_host_model dcb_host_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .stall_i(stall), .out_valid_i(out_valid_o), .out_chan_i(out_chan_o),
        .out_data_i(out_data_o), .out_ready_o(out_ready_i));

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ****************************************************************
    // Modulator ticks every fourth cycle, window and ready timestamps
    // ****************************************************************
    always @(posedge clk_i)
    begin
        for (int c = 0; c < NUM_CH; c++)
            if (chan_window_o[c] === 1'b1)
                pcyc[c] = cyc;
        if (result_ready_n_o === 1'b0)
            rcyc = cyc;
        mod_tick_i <= (cyc % 4 == 3);
        cyc = cyc + 1;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", compares,
            mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do
            @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask

    task automatic push(input int ch, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        res_valid_i <= 1'b1;
        res_chan_i <= ch[CH_W-1:0];
        res_data_i <= d;
        do
            @(posedge clk_i);
        while (res_ready_o !== 1'b1);
        res_valid_i <= 1'b0;
    endtask

    task automatic pull(input int ch, input logic [DATA_W-1:0] d);
        logic [BUF_W-1:0] got;
        got = 'x;
        repeat (50)
            if (dcb_host_model_i.rx_q.size() == 0)
                @(posedge clk_i);
        if (dcb_host_model_i.rx_q.size() != 0)
            got = dcb_host_model_i.rx_q.pop_front();
        check({5'h00, got}, {5'h00, ch[CH_W-1:0], d});
    endtask

    function automatic int clip(input int t, input int osr);
        int h;
        h = (osr > 1024) ? 512 : osr / 2;
        return t < -h ? -h : (t > h - 1 ? h - 1 : t);
    endfunction

    // Window offset of each channel against channel 0, in ticks
    task automatic trim_test(input int s);
        int osr;
        int d, e;
        osr = 128 << s;
        wr(ADDR_GLOBAL, 32'(s << 4));
        for (int c = 1; c < NUM_CH; c++)
            wr(ADDR_CHAN_BASE + 8'(4 * c), 32'(tr[c]) & 32'h000003FF);
        repeat (osr * 8 + 20) @(posedge clk_i);
        for (int c = 1; c < NUM_CH; c++)
        begin
            d = ((pcyc[c] - pcyc[0]) / 4 % osr + osr) % osr;
            e = (clip(tr[c], osr) + osr) % osr;
            check(d, e);
        end
        $display("Test phase trim at ratio %0d done", osr);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({22'h000000, avs_waitrequest_o, result_ready_n_o, res_ready_o,
            out_valid_o, chan_window_o}, 32'h00000380);
        rd_chk(ADDR_GLOBAL, 32'h00000030);
        rd_chk(ADDR_CHAN_LAST, 32'h00000000);
        wr(8'h08, 32'hFFFFFFFF);
        rd_chk(8'h08, 32'h00000000);
        wr(ADDR_CHAN_LAST, 32'h00003412);
        rd_chk(ADDR_CHAN_LAST, 32'h00003412);
        wr(ADDR_CHAN_LAST, 32'h00000000);
        $display("Test registers done");
        wr(ADDR_GLOBAL, 32'h00000000);
        repeat (1100) @(posedge clk_i);
        for (int c = 1; c < NUM_CH; c++)
            check(pcyc[c], pcyc[0]);
        check(rcyc, pcyc[0] + 1);
        $display("Test aligned windows done");
        for (int s = 0; s < 2; s++)
            trim_test(s);
        wr(ADDR_GLOBAL, 32'h00000000);
        push(0, 24'h123456);
        pull(0, 24'h123456);
        for (int k = 1; k < 4; k++)
        begin
            wr(ADDR_CHAN_BASE + 8'h04, 32'(k << 12));
            push(1, 24'h0ABCDE);
            pull(1, lvl[k - 1]);
        end
        $display("Test input select done");
        wr(ADDR_CHAN_BASE + 8'h08, 32'h00000400);
        for (int k = 1; k < 4; k++)
        begin
            wr(ADDR_GLOBAL, 32'(k));
            push(k + 2, 24'h100000);
            pull(k + 2, 24'h100000);
            push(k + 2, 24'h100000);
            pull(k + 2, 24'h100000 - (24'h080000 >> k));
            push(2, 24'h100000);
            pull(2, 24'h100000);
        end
        $display("Test high-pass filter done");
        wr(ADDR_GLOBAL, 32'h00000000);
        stall <= 1'b1;
        push(0, 24'h000001);
        push(0, 24'h000002);
        repeat (3) @(posedge clk_i);
        check({30'h00000000, res_ready_o, out_valid_o}, 32'h00000001);
        stall <= 1'b0;
        push(0, 24'h000003);
        for (int k = 1; k < 4; k++)
            pull(0, 24'(k));
        $display("Test buffer stall done");
        stop_test;
    end

    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        $display("Error %0t: run did not finish in time", $time);
        stop_test;
    end
endmodule

`default_nettype wire
